// File: src/iwc_ctrl.sv
// iwc_ctrl: idle-mode entry and wake control with apb register access
// assumes: apb master on pclk, wake sources and clock loss synchronous to pclk
// Function
// - secondary idle: cpu stopped, peripherals on secondary
// - to secondary: primary off, flags updated
// - secondary wake: stay secondary, cpu after delay
// - no secondary enable: keep previous clock mode
// - internal idle: peripherals on internal multiplexer
// - to internal: primary off, frequency kept
// - fast oscillator enable; flag after settle
// - already stable flags survive idle entry
// - all clear: oscillator off, flags clear
// - medium select picks reported stability flag
// - internal wake: stay internal, cpu after delay
// - slow oscillator runs with watchdog/monitor
// - wake only by interrupt, reset, watchdog
// - enabled interrupt flag set starts wake
// - after irq wake: vector if global enable
// - fixed wake delay before execution restarts
// - watchdog: wake in idle, reset in run
// - watchdog cleared by halt, clear, loss, freq
// - reset wake restarts at address zero
// - startup timer skipped unless crystal leaving sleep
// - execution continues while fast oscillator settles
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "iwc_defs.svh"
module iwc_ctrl
    import iwc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic irq_flag,
    input wire logic irq_enable,
    input wire logic wdt_timeout,
    input wire logic ext_reset,
    input wire logic clock_lost,
    input wire logic [3:0] sec_timer_osc_en,
    output iwc_clk_t clk_ctl,
    output logic wdt_clear,
    output logic wdt_reset,
    output logic cpu_vector,
    output logic cpu_restart_zero,
    output logic cpu_resume
);
    // register state
    logic [31:0] ctrl_reg;
    iwc_state_t state_reg;
    iwc_src_t src_reg;
    logic pri_run_reg;
    logic sec_act_reg;
    logic fast_ok_reg;
    logic med_ok_reg;
    logic was_irq_reg;
    logic was_rst_reg;
    logic [31:0] prdata_reg;
    iwc_clk_t clk_reg;
    logic wdt_clear_reg;
    logic wdt_reset_reg;
    logic vec_reg;
    logic zero_reg;
    logic resume_reg;
    logic pslverr_reg; // error answer, stands for the access cycle

    // apb decode
    wire logic acc = psel && penable;
    wire logic wr = acc && pwrite;
    wire logic hit_ctrl = (paddr == `IWC_CTRL_OFS);
    wire logic hit_stat = (paddr == `IWC_STAT_OFS);
    wire logic hit_cmd = (paddr == `IWC_CMD_OFS);
    wire logic unmapped = !(hit_ctrl || hit_stat || hit_cmd);
    wire logic wr_ctrl = wr && hit_ctrl;
    wire logic halt_cmd = wr && hit_cmd && pwdata[`IWC_CMD_HALT];
    wire logic clr_cmd = wr && hit_cmd && pwdata[`IWC_CMD_WDTCLR];

    // control fields
    wire logic sel_hi = ctrl_reg[`IWC_CTRL_SEL_HI];
    wire logic sel_lo = ctrl_reg[`IWC_CTRL_SEL_LO];
    wire logic idle_on_sleep = ctrl_reg[`IWC_CTRL_IDLE];
    wire logic [2:0] freq = ctrl_reg[`IWC_CTRL_FREQ_MSB:`IWC_CTRL_FREQ_LSB];
    wire logic lf_src = ctrl_reg[`IWC_CTRL_LFSRC];
    wire logic med_sel = ctrl_reg[`IWC_CTRL_MEDSEL];
    wire logic gie = ctrl_reg[`IWC_CTRL_GIE];
    wire logic wdt_en = ctrl_reg[`IWC_CTRL_WDT_EN];
    wire logic fscm_en = ctrl_reg[`IWC_CTRL_FSCM_EN];
    wire logic xtal = ctrl_reg[`IWC_CTRL_XTAL];
    wire logic [2:0] new_freq = pwdata[`IWC_CTRL_FREQ_MSB:`IWC_CTRL_FREQ_LSB];

    // switching is immediate in run; a secondary select with no
    // secondary enable leaves the current owner in place
    // secondary enabled by any of the enable bits
    wire logic sec_any = ctrl_reg[`IWC_CTRL_SECONDARY_OSC_GO] || (|sec_timer_osc_en);
    // requested source; low select bit ignored under high bit
    wire logic want_int = sel_hi;
    wire logic want_sec = !sel_hi && sel_lo && sec_any;
    wire iwc_src_t target = want_int ? IWC_SRC_INT : (want_sec ? IWC_SRC_SEC : src_reg);
    // fast oscillator output enable
    wire logic fast_need = (freq != 3'b000) || lf_src || med_sel;
    // which flag the current setting reports
    wire logic rep_med = med_sel && ((freq != 3'b000) || lf_src);
    wire logic rep_fast = !med_sel && ((freq != 3'b000) || lf_src);
    // wake triggers
    // a cause only counts while stopped; in run a time-out resets instead
    wire logic irq_wake = irq_flag && irq_enable;
    wire logic sleeping = (state_reg == IWC_IDLE) || (state_reg == IWC_SLEEP);
    wire logic wake_ev = sleeping && (irq_wake || ext_reset || wdt_timeout);
    // start-up timer only leaving sleep onto a crystal primary
    wire logic need_ost = (state_reg == IWC_SLEEP) && (src_reg == IWC_SRC_PRI) && xtal;
    wire logic running = (state_reg == IWC_RUN);
    wire logic int_drive = (src_reg == IWC_SRC_INT);
    wire logic freq_change = wr_ctrl && (new_freq != freq) && int_drive;

    // the three counters run side by side; the wake delay and the start-up
    // timer gate the cpu, the settle timer only raises the stability flags
    // counter handshakes
    logic wake_done;
    logic wake_busy;
    logic settle_done;
    logic settle_busy;
    logic ost_done;
    logic ost_busy;
    wire logic settle_start = fast_need && !fast_ok_reg && !med_ok_reg && !settle_busy && !settle_done;

    // cpu wake delay, runs alongside the others
    iwc_delay #(.CYCLES(`IWC_WAKE_CYC)) u_wake (
        .pclk(pclk),
        .presetn(presetn),
        .start(wake_ev),
        .abort(1'b0),
        .busy(wake_busy),
        .done(wake_done)
    );
    // internal oscillator settle timer
    // aborted as soon as the fast output is switched off
    iwc_delay #(.CYCLES(`IWC_SETTLE_CYC)) u_settle (
        .pclk(pclk),
        .presetn(presetn),
        .start(settle_start),
        .abort(!fast_need),
        .busy(settle_busy),
        .done(settle_done)
    );
    // oscillator start-up timer
    iwc_delay #(.CYCLES(`IWC_OST_CYC)) u_ost (
        .pclk(pclk),
        .presetn(presetn),
        .start(wake_ev && need_ost),
        .abort(1'b0),
        .busy(ost_busy),
        .done(ost_done)
    );

    // wake finishes when wake delay has expired and no start-up timer remains
    // a wake event only fires while idle or asleep, so its term never holds the finish off
    wire logic wake_fin = (state_reg == IWC_WAKE) && !wake_busy && !ost_busy && !wake_ev;

    // control register: software writes, wake never touches mode bits
    // writes outside run are dropped so a wake can never see its
    // mode bits move under it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_reg <= `IWC_CTRL_RESET;
        else if (wr_ctrl && running)
            ctrl_reg <= pwdata;
    end

    // power state machine
    // halt only acts from run; a halt written while stopped is ignored
    // the wake cause is latched so the restart pulses can tell
    // a reset exit from an interrupt exit once the delay has run out
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= IWC_RUN;
            src_reg <= IWC_SRC_PRI;
            was_irq_reg <= 1'b0;
            was_rst_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                IWC_RUN:
                begin
                    src_reg <= target;
                    if (halt_cmd)
                        state_reg <= idle_on_sleep ? IWC_IDLE : IWC_SLEEP;
                end
                IWC_IDLE, IWC_SLEEP:
                begin
                    if (wake_ev)
                    begin
                        state_reg <= IWC_WAKE;
                        was_irq_reg <= irq_wake && !ext_reset;
                        was_rst_reg <= ext_reset;
                    end
                end
                IWC_WAKE:
                begin
                    if (wake_fin)
                        state_reg <= IWC_RUN;
                end
            endcase
        end
    end

    // clock status flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pri_run_reg <= 1'b1;
            sec_act_reg <= 1'b0;
            fast_ok_reg <= 1'b0;
            med_ok_reg <= 1'b0;
        end
        else
        begin
            // source change flags
            pri_run_reg <= (src_reg == IWC_SRC_PRI) && (state_reg != IWC_SLEEP);
            sec_act_reg <= (src_reg == IWC_SRC_SEC);
            // stability: set on settle end, kept while enabled, cleared when off
            // a flag already stable before halt stays, nothing re-arms the timer
            if (!fast_need)
            begin
                fast_ok_reg <= 1'b0;
                med_ok_reg <= 1'b0;
            end
            else if (settle_done || fast_ok_reg || med_ok_reg)
            begin
                fast_ok_reg <= rep_fast;
                med_ok_reg <= rep_med;
            end
        end
    end

    // clock enables toward core; peripherals run through settling
    // the cpu gate opens on the same edge as the resume pulse, so the
    // core never sees a clock before it is told where to restart
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            clk_reg <= '{cpu_clk_en: 1'b1, periph_clk_en: 1'b1, pri_osc_en: 1'b1,
                         sec_osc_en: 1'b0, fast_osc_en: 1'b0, slow_osc_en: 1'b1};
        else
        begin
            clk_reg.cpu_clk_en <= running || wake_fin;
            clk_reg.periph_clk_en <= (state_reg != IWC_SLEEP) || wake_fin;
            clk_reg.pri_osc_en <= (src_reg == IWC_SRC_PRI) && (state_reg != IWC_SLEEP);
            clk_reg.sec_osc_en <= sec_any || (src_reg == IWC_SRC_SEC);
            clk_reg.fast_osc_en <= fast_need;
            clk_reg.slow_osc_en <= wdt_en || fscm_en || !fast_need;
        end
    end

    // watchdog clear and reset pulses
    // a time-out while stopped is a wake cause, never a reset
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wdt_clear_reg <= 1'b0;
            wdt_reset_reg <= 1'b0;
        end
        else
        begin
            wdt_clear_reg <= halt_cmd || clr_cmd || (clock_lost && fscm_en) || freq_change;
            wdt_reset_reg <= wdt_timeout && running;
        end
    end

    // cpu restart indications, one pulse at resume
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            vec_reg <= 1'b0;
            zero_reg <= 1'b0;
            resume_reg <= 1'b0;
        end
        else
        begin
            resume_reg <= wake_fin;
            vec_reg <= wake_fin && was_irq_reg && gie;
            zero_reg <= wake_fin && was_rst_reg;
        end
    end

    // apb read mux and answer
    // the command word reads as zero; it only carries strobes
    wire logic [31:0] stat_word = {24'h00_0000, running, 1'b0, state_reg[1:0],
                                   med_ok_reg, fast_ok_reg, sec_act_reg, pri_run_reg};
    wire logic [31:0] rd_mux = hit_ctrl ? ctrl_reg : (hit_stat ? stat_word : 32'h0000_0000);

    // zero-wait answer registered on setup
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata_reg <= 32'h0000_0000;
        end
        else if (psel && !penable)
        begin
            prdata_reg <= rd_mux;
        end
    end

    // error answer registered at setup, dropped again at the access edge
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pslverr_reg <= 1'b0;
        end
        else
        begin
            pslverr_reg <= psel && !penable && unmapped;
        end
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = pslverr_reg;
    assign clk_ctl = clk_reg;
    assign wdt_clear = wdt_clear_reg;
    assign wdt_reset = wdt_reset_reg;
    assign cpu_vector = vec_reg;
    assign cpu_restart_zero = zero_reg;
    assign cpu_resume = resume_reg;
endmodule : iwc_ctrl
`default_nettype wire

// File: src/iwc_defs.svh
// iwc_defs.svh: offsets, field positions, reset values and timing counts for the idle/wake controller
// assumes: included by bare name, clock is pclk at 125 MHz
`ifndef IWC_DEFS_SVH
`define IWC_DEFS_SVH

// clock period in picoseconds
`define IWC_CLK_PERIOD_PS 8000
// cpu wake delay, in ns
`define IWC_WAKE_DELAY_NS 1000
// internal oscillator settle time, in ns
`define IWC_SETTLE_NS 2000
// oscillator start-up time, in ns
`define IWC_OST_NS 8000
// cycle counts derived from the times (round up)
`define IWC_WAKE_CYC ((`IWC_WAKE_DELAY_NS * 1000 + `IWC_CLK_PERIOD_PS - 1) / `IWC_CLK_PERIOD_PS)
`define IWC_SETTLE_CYC ((`IWC_SETTLE_NS * 1000 + `IWC_CLK_PERIOD_PS - 1) / `IWC_CLK_PERIOD_PS)
`define IWC_OST_CYC ((`IWC_OST_NS * 1000 + `IWC_CLK_PERIOD_PS - 1) / `IWC_CLK_PERIOD_PS)

// register byte offsets
`define IWC_CTRL_OFS 12'h000
`define IWC_STAT_OFS 12'h004
`define IWC_CMD_OFS 12'h008

// control register fields
`define IWC_CTRL_SEL_LO 0
`define IWC_CTRL_SEL_HI 1
`define IWC_CTRL_IDLE 2
`define IWC_CTRL_FREQ_LSB 4
`define IWC_CTRL_FREQ_MSB 6
`define IWC_CTRL_LFSRC 7
`define IWC_CTRL_MEDSEL 8
`define IWC_CTRL_SECONDARY_OSC_GO 9
`define IWC_CTRL_GIE 10
`define IWC_CTRL_WDT_EN 11
`define IWC_CTRL_FSCM_EN 12
`define IWC_CTRL_XTAL 13
`define IWC_CTRL_RESET 32'h0000_0000

// command register fields (write one to act)
`define IWC_CMD_HALT 0
`define IWC_CMD_WDTCLR 1

// status register fields
`define IWC_ST_PRI_RUN 0
`define IWC_ST_SEC_ACT 1
`define IWC_ST_FAST_OK 2
`define IWC_ST_MED_OK 3
`define IWC_ST_MODE_LSB 4
`define IWC_ST_MODE_MSB 6
`define IWC_ST_CPU_RUN 7

`endif

// File: src/iwc_pkg.sv
// iwc_pkg: types for the idle/wake controller
// assumes: used together with iwc_defs.svh
package iwc_pkg;
    // power state of the controller
    typedef enum logic [2:0] {
        IWC_RUN,
        IWC_IDLE,
        IWC_SLEEP,
        IWC_WAKE
    } iwc_state_t;
    // clock owner of the system
    typedef enum logic [1:0] {
        IWC_SRC_PRI,
        IWC_SRC_SEC,
        IWC_SRC_INT
    } iwc_src_t;
    // clock enables toward the core
    typedef struct packed {
        logic cpu_clk_en;
        logic periph_clk_en;
        logic pri_osc_en;
        logic sec_osc_en;
        logic fast_osc_en;
        logic slow_osc_en;
    } iwc_clk_t;
    // wake-up sources
    typedef struct packed {
        logic irq;
        logic rst;
        logic wdt;
    } iwc_wake_t;
endpackage : iwc_pkg

// File: src/iwc_delay.sv
// iwc_delay: one-shot cycle down-counter, start pulse loads, one-cycle done pulse on expiry
// assumes: single clock pclk, asynchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module iwc_delay
    import iwc_pkg::*;
#(
    parameter int CYCLES = 1
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic abort,
    output logic busy,
    output logic done
);
    localparam int W = $clog2(CYCLES + 1);
    // remaining cycles
    logic [W-1:0] cnt_reg;

    // load on start, count down, done when reaching zero
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_reg <= '0;
            done <= 1'b0;
        end
        else if (abort)
        begin
            cnt_reg <= '0;
            done <= 1'b0;
        end
        else if (start)
        begin
            cnt_reg <= W'(CYCLES);
            done <= 1'b0;
        end
        else if (cnt_reg != '0)
        begin
            cnt_reg <= cnt_reg - W'(1);
            done <= (cnt_reg == W'(1));
        end
        else
        begin
            done <= 1'b0;
        end
    end
    assign busy = (cnt_reg != '0);
endmodule : iwc_delay
`default_nettype wire

// File: sim/iwc_ctrl_chk.sv
// iwc_ctrl_chk: port-level timing checks for the idle/wake controller
// assumes: bound into iwc_ctrl, single clock pclk
`timescale 1ns/1ps
`default_nettype none
`include "iwc_defs.svh"
module iwc_ctrl_chk
    import iwc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic irq_flag,
    input wire logic irq_enable,
    input wire logic wdt_timeout,
    input wire logic ext_reset,
    input wire iwc_clk_t clk_ctl,
    input wire logic wdt_clear,
    input wire logic wdt_reset,
    input wire logic cpu_restart_zero,
    input wire logic cpu_resume
);
    localparam int WAKE_CYC = `IWC_WAKE_CYC; // cpu wake delay in cycles
    logic [11:0] wake_cnt; // cycles since a wake cause while stopped
    logic woke; // a wake cause was seen while stopped
    logic [11:0] irq_age; // cycles since an enabled flag rose while stopped
    logic irq_seen; // enabled flag level one cycle ago
    wire logic cause = (irq_flag & irq_enable) | wdt_timeout | ext_reset;
    wire logic cmd_wr = psel && penable && pwrite && paddr == `IWC_CMD_OFS;
    wire logic clr_wr = cmd_wr && (pwdata[`IWC_CMD_HALT] || pwdata[`IWC_CMD_WDTCLR]);
    // track the wake cause and its age while the cpu clock is stopped
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn || clk_ctl.cpu_clk_en)
        begin
            wake_cnt <= '0;
            woke <= 1'b0;
        end
        else
        begin
            wake_cnt <= (woke || cause) ? wake_cnt + 12'h001 : 12'h000;
            woke <= woke | cause;
        end
    end
    // age of an enabled interrupt that arrived while stopped, cleared by the restart pulses
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_age <= 12'h000;
            irq_seen <= 1'b0;
        end
        else
        begin
            irq_seen <= irq_flag && irq_enable;
            if (cpu_resume || cpu_restart_zero)
                irq_age <= 12'h000;
            else if (irq_age != 12'h000 || (irq_flag && irq_enable && !irq_seen && !clk_ctl.cpu_clk_en))
                irq_age <= irq_age + 12'h001;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_HALT_STOPS_CPU:
        assert property (cmd_wr && pwdata[`IWC_CMD_HALT] |-> ##[1:3] !clk_ctl.cpu_clk_en) else $error("cpu kept running");
    AST_WDT_CLEARED:
        assert property (clr_wr |-> ##[0:2] wdt_clear) else $error("watchdog not cleared");
    AST_WAKE_NEEDS_CAUSE:
        assert property ($rose(clk_ctl.cpu_clk_en) |-> woke) else $error("wake without cause");
    AST_WAKE_DELAY:
        assert property ($rose(clk_ctl.cpu_clk_en) |-> wake_cnt >= WAKE_CYC) else $error("wake delay short");
    AST_IRQ_WAKES:
        assert property (irq_age <= 12'h4b0) else $error("irq did not wake");
    AST_RESUME_RUNS_CPU:
        assert property (cpu_resume |-> ##[0:2] clk_ctl.cpu_clk_en) else $error("cpu gate held");
    AST_RESUME_ONE_SHOT:
        assert property (cpu_resume |=> !cpu_resume) else $error("resume pulse long");
    AST_WDT_RESET_RUN:
        assert property (wdt_reset |-> $past(clk_ctl.cpu_clk_en)) else $error("watchdog reset while stopped");
    AST_WDT_WAKE_ONLY:
        assert property (wdt_timeout && !clk_ctl.cpu_clk_en |-> ##1 !wdt_reset [*3]) else $error("reset in idle");
    cover property ($rose(clk_ctl.cpu_clk_en));
    cover property (cpu_restart_zero);
    cover property (wdt_reset);
endmodule : iwc_ctrl_chk
bind iwc_ctrl iwc_ctrl_chk iwc_ctrl_chk_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .irq_flag(irq_flag), .irq_enable(irq_enable),
    .wdt_timeout(wdt_timeout), .ext_reset(ext_reset), .clk_ctl(clk_ctl), .wdt_clear(wdt_clear),
    .wdt_reset(wdt_reset), .cpu_restart_zero(cpu_restart_zero), .cpu_resume(cpu_resume));
`default_nettype wire

// File: sim/iwc_core_model.sv
// iwc_core_model: cpu core, interrupt source and watchdog/reset requesters
// assumes: bench pulses kick for one cycle; the handler clears the flag on resume
`timescale 1ns/1ps
`default_nettype none
module iwc_core_model
    import iwc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire iwc_wake_t kick,
    input wire logic en_req,
    input wire logic [7:0] lag,
    input wire logic cpu_resume,
    output logic irq_flag,
    output logic irq_enable,
    output logic wdt_timeout,
    output logic ext_reset
);
    logic [8:0] lag_cnt; // cycles until the flag shows, zero when idle
    // flag rises after the lag, requests follow kick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            irq_flag <= 1'b0;
            irq_enable <= 1'b0;
            wdt_timeout <= 1'b0;
            ext_reset <= 1'b0;
            lag_cnt <= '0;
        end
        else
        begin
            irq_enable <= en_req;
            wdt_timeout <= kick.wdt;
            ext_reset <= kick.rst;
            lag_cnt <= kick.irq ? {1'b0, lag} + 9'h001 : lag_cnt - {8'h00, lag_cnt != 9'h000};
            if (lag_cnt == 9'h001)
                irq_flag <= 1'b1;
            else if (cpu_resume)
                irq_flag <= 1'b0;
        end
    end
endmodule : iwc_core_model
`default_nettype wire

// File: sim/tb_idle_mode_and_wake_control.sv
// tb_idle_mode_and_wake_control: directed idle entry and wake scenarios
// assumes: design, core model and bound checker compiled before
`timescale 1ns/1ps
`default_nettype none
`include "iwc_defs.svh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_errors++; $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_idle_mode_and_wake_control
    import iwc_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, en_req = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] sec_en = 4'h0; // timer secondary osc enables
    logic lost = 1'b0; // clock loss seen by the monitor
    logic [7:0] lag = 8'h28; // model answers slowly
    iwc_wake_t kick = '0; // wake request to the model
    wire logic [31:0] prdata;
    wire logic pready, pslverr, irq_flag, irq_enable, wdt_timeout, ext_reset;
    wire logic wdt_clear, wdt_reset, cpu_vector, cpu_restart_zero, cpu_resume;
    wire iwc_clk_t clk_ctl;
    int n_errors = 0, total_checks = 0, cyc = 0;
    always #4 pclk = ~pclk;
    iwc_ctrl iwc_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .irq_flag(irq_flag), .irq_enable(irq_enable), .wdt_timeout(wdt_timeout), .ext_reset(ext_reset),
        .clock_lost(lost), .sec_timer_osc_en(sec_en), .clk_ctl(clk_ctl), .wdt_clear(wdt_clear), .wdt_reset(wdt_reset),
        .cpu_vector(cpu_vector), .cpu_restart_zero(cpu_restart_zero), .cpu_resume(cpu_resume));
    iwc_core_model iwc_core_model_inst (.pclk(pclk), .presetn(presetn), .kick(kick), .en_req(en_req),
        .lag(lag), .cpu_resume(cpu_resume), .irq_flag(irq_flag), .irq_enable(irq_enable),
        .wdt_timeout(wdt_timeout), .ext_reset(ext_reset));
    task automatic wrap_up;
        if (n_errors == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up
    // one apb transfer; r is error flag over read data
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [32:0] r);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = {pslverr, prdata};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic halt;
        logic [32:0] r;
        apb(1'b1, `IWC_CMD_OFS, 32'h0000_0001, r);
        #1;
        `CHK(wdt_clear, 1'b1)
        repeat (3) @(posedge pclk);
        #1;
    endtask : halt
    task automatic pulse(input iwc_wake_t k);
        @(posedge pclk);
        kick <= k;
        @(posedge pclk);
        kick <= '0;
    endtask : pulse
    // count cycles to the end of wake, note a vector pulse
    task automatic wait_wake(output int n, output logic v);
        n = 0;
        v = 1'b0;
        while (cpu_resume !== 1'b1 && cpu_restart_zero !== 1'b1 && n < 2000)
        begin
            @(posedge pclk);
            #1;
            n++;
            v = v | (cpu_vector === 1'b1);
        end
    endtask : wait_wake
    task automatic t_regs;
        logic [32:0] r;
        apb(1'b0, `IWC_CTRL_OFS, '0, r);
        `CHK(r, 33'h0_0000_0000)
        apb(1'b0, `IWC_STAT_OFS, '0, r);
        `CHK(r[7:0], 8'h81)
        apb(1'b0, 12'h0fc, '0, r);
        `CHK(r, 33'h1_0000_0000)
    endtask : t_regs
    task automatic t_wdt_run;
        logic s;
        s = 1'b0;
        pulse(3'b001);
        repeat (6)
        begin
            @(posedge pclk);
            #1;
            s = s | (wdt_reset === 1'b1);
        end
        `CHK(s, 1'b1)
    endtask : t_wdt_run
    task automatic t_no_sec;
        logic [32:0] r;
        int n;
        logic v;
        apb(1'b1, `IWC_CTRL_OFS, 32'h0000_1005, r);
        halt();
        `CHK(clk_ctl[5:1], 5'b01100)
        @(posedge pclk);
        lost <= 1'b1;
        @(posedge pclk);
        lost <= 1'b0;
        #1;
        `CHK(wdt_clear, 1'b1)
        pulse(3'b001);
        wait_wake(n, v);
        `CHK(cpu_resume, 1'b1)
    endtask : t_no_sec
    task automatic t_irq;
        logic [32:0] r;
        int n;
        logic v;
        for (int g = 0; g < 2; g++)
        begin
            apb(1'b1, `IWC_CTRL_OFS, {21'h0, g[0], 10'h004}, r);
            halt();
            pulse(3'b100);
            repeat (200) @(posedge pclk);
            #1;
            `CHK(clk_ctl.cpu_clk_en, 1'b0)
            @(posedge pclk);
            en_req <= 1'b1;
            wait_wake(n, v);
            `CHK({cpu_resume, v}, {1'b1, g[0]})
            @(posedge pclk);
            en_req <= 1'b0;
        end
    endtask : t_irq
    task automatic t_sec;
        logic [32:0] r;
        int n;
        logic v;
        @(posedge pclk);
        sec_en <= 4'b0010;
        en_req <= 1'b1;
        apb(1'b1, `IWC_CTRL_OFS, 32'h0000_0004, r);
        apb(1'b1, `IWC_CTRL_OFS, 32'h0000_0005, r);
        halt();
        `CHK(clk_ctl[5:1], 5'b01010)
        apb(1'b0, `IWC_STAT_OFS, '0, r);
        `CHK({r[5:4], r[1:0]}, 4'b0110)
        pulse(3'b100);
        wait_wake(n, v);
        `CHK(n >= `IWC_WAKE_CYC + 40 && n <= `IWC_WAKE_CYC + 50, 1'b1)
        `CHK(clk_ctl[5:2], 4'b1101)
        apb(1'b0, `IWC_CTRL_OFS, '0, r);
        `CHK(r, 33'h0_0000_0005)
        en_req <= 1'b0;
    endtask : t_sec
    task automatic t_int;
        logic [32:0] r;
        int n;
        logic v;
        apb(1'b1, `IWC_CTRL_OFS, 32'h0000_0004, r);
        sec_en <= 4'b0000;
        apb(1'b1, `IWC_CTRL_OFS, 32'h0000_0827, r);
        halt();
        `CHK(clk_ctl, 6'b010011)
        repeat (`IWC_SETTLE_CYC + 4) @(posedge pclk);
        apb(1'b0, `IWC_STAT_OFS, '0, r);
        `CHK(r[3:0], 4'b0100)
        pulse(3'b010);
        wait_wake(n, v);
        `CHK({cpu_restart_zero, n >= `IWC_WAKE_CYC}, 2'b11)
    endtask : t_int
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 30000)
        begin
            n_errors++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_wdt_run();
        t_no_sec();
        t_irq();
        t_sec();
        t_int();
        wrap_up();
    end
endmodule : tb_idle_mode_and_wake_control
`default_nettype wire
